/* File: rtl/aout_pkg.sv */
package aout_pkg;
  typedef enum logic [1:0] {
    HM_CLEAR = 2'b00,
    HM_LAST  = 2'b01,
    HM_MAX   = 2'b10
  } hold_mode_e;
  typedef logic signed [15:0] word_t;
  typedef logic [3:0][15:0]   out_bus_t;
endpackage

/* File: rtl/aout_regs.svh */
`ifndef AOUT_REGS_SVH
`define AOUT_REGS_SVH

// configuration word offsets from the unit's base
`define OUT1_HOLD_MODE   5'h03
`define OUT1_SCALE_LOW   5'h04
`define OUT1_SCALE_HIGH  5'h05
`define OUT2_HOLD_MODE   5'h07
`define OUT2_SCALE_LOW   5'h08
`define OUT2_SCALE_HIGH  5'h09
`define OUT3_HOLD_MODE   5'h0b
`define OUT3_SCALE_LOW   5'h0c
`define OUT3_SCALE_HIGH  5'h0d
`define OUT4_HOLD_MODE   5'h0f
`define OUT4_SCALE_LOW   5'h10
`define OUT4_SCALE_HIGH  5'h11

// reset values
`define SCALE_LIMIT_RST  16'h0000
`define HOLD_MODE_RST    16'h0000
`define SET_VALUE_RST    16'h0000
`define STATUS_RST       16'h0000

// status word fields
`define STAT_SET_ERR_LSB 0
`define STAT_CFG_ERR_BIT 8
`define STAT_HOLD_ERR_BIT 10
`define HOLD_MODE_MAXVAL 16'h0002

// legal scaling limits, two's complement
`define SCALE_LIM_MAX    16'sh7d00
`define SCALE_LIM_MIN    16'sh8300

// converter full scale in output codes (0% .. 100%)
`define DAC_FULL_SCALE   34'sh0_0000_0fa0
`define DAC_FIVE_PCT_DIV 34'sh0_0000_0014
`define DAC_CLR_LEVEL    (-(`DAC_FULL_SCALE / `DAC_FIVE_PCT_DIV))
`define DAC_MAX_LEVEL    (`DAC_FULL_SCALE + (`DAC_FULL_SCALE / `DAC_FIVE_PCT_DIV))

`endif

/* File: rtl/aout_unit.sv */
// Summary of operation
// RULE1: scaling limits are 16-bit two's complement, -32000 to 32000.
// RULE2: valid limits map set value linearly, low limit 0%, high limit 100%.
// RULE3: low limit above high limit gives reverse scaling.
// RULE4: only results from -5% to +105% of full scale are converted.
// RULE5: equal limits or limits beyond +/-32000 flag error and skip scaling.
// RULE6: both limits zero bypasses scaling with no error.
// RULE7: output limits sit at words 4/5, 8/9, 12/13, 16/17 of configuration area.
// RULE8: host places configuration base at 20000 plus 100 times unit number.
// RULE9: over-range set value sets its output flag, status bits 0 to 3.
// RULE10: host places status base at 2000 plus 10 times unit number.
// RULE11: an output in error drives its hold level instead of the conversion.
// RULE12: run lamp lit in normal operation, dark when host exchange stopped.
// RULE13: unit error lamp lit on any alarm or bad initial configuration.
// RULE14: host error lamp lit when host data exchange fails.
// RULE15: hold code 0 drives clear level, 1 holds last, 2 drives maximum.
// RULE16: scaling configuration error reported on status bit 8.
// RULE17: set value error flags clear themselves once the cause is gone.
// RULE18: scaling uses wide signed arithmetic, division truncates toward zero.
`include "aout_regs.svh"

module aout_unit (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               cfg_wr_en,
  input  wire logic [4:0]         cfg_addr,
  input  wire logic [15:0]        cfg_wr_data,
  input  wire logic               sv_wr_en,
  input  wire logic [1:0]         sv_sel,
  input  wire logic [15:0]        sv_wr_data,
  input  wire logic               io_refresh,
  input  wire logic [3:0]         conv_enable,
  input  wire logic               host_link_ok,
  input  wire logic               bus_error,
  output logic [15:0]             status_word,
  output aout_pkg::out_bus_t      dac_out,
  output logic                    run_lamp,
  output logic                    unit_error_lamp,
  output logic                    host_error_lamp
);
  import aout_pkg::*;

  localparam logic [4:0] LOW_OFF  [4] = '{`OUT1_SCALE_LOW, `OUT2_SCALE_LOW,
                                          `OUT3_SCALE_LOW, `OUT4_SCALE_LOW};
  localparam logic [4:0] HIGH_OFF [4] = '{`OUT1_SCALE_HIGH, `OUT2_SCALE_HIGH,
                                          `OUT3_SCALE_HIGH, `OUT4_SCALE_HIGH};
  localparam logic [4:0] HOLD_OFF [4] = '{`OUT1_HOLD_MODE, `OUT2_HOLD_MODE,
                                          `OUT3_HOLD_MODE, `OUT4_HOLD_MODE};
  localparam logic [15:0] CLR_CODE = 16'(`DAC_CLR_LEVEL);
  localparam logic [15:0] MAX_CODE = 16'(`DAC_MAX_LEVEL);
  localparam logic [15:0] FULL_CODE = 16'(`DAC_FULL_SCALE);

  logic [15:0] low_r   [4];
  logic [15:0] high_r  [4];
  logic [15:0] hold_r  [4];
  logic [15:0] sv_r    [4];
  logic [15:0] dac_r   [4];
  logic [15:0] dac_nxt [4];
  logic [3:0]  stop;
  logic [3:0]  range_err;
  logic [3:0]  cfg_err;
  logic [3:0]  hold_bad;
  logic [3:0]  set_err_r;
  logic        cfg_err_r;
  logic        hold_err_r;
  logic        host_err_r;
  logic        init_err;
  logic        run_r;
  logic        unit_err_r;

  scale_if sif [4] ();

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ch
      hold_mode_e mode;

      // configuration words decoded at their own offsets [RULE7]
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          low_r[i]  <= `SCALE_LIMIT_RST;
          high_r[i] <= `SCALE_LIMIT_RST;
          hold_r[i] <= `HOLD_MODE_RST;
        end else if (cfg_wr_en) begin
          if (cfg_addr == LOW_OFF[i]) begin
            low_r[i] <= cfg_wr_data;
          end
          if (cfg_addr == HIGH_OFF[i]) begin
            high_r[i] <= cfg_wr_data;
          end
          if (cfg_addr == HOLD_OFF[i]) begin
            hold_r[i] <= cfg_wr_data;
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          sv_r[i] <= `SET_VALUE_RST;
        end else if (sv_wr_en && (sv_sel == 2'(i))) begin
          sv_r[i] <= sv_wr_data;
        end
      end

      assign sif[i].set_value = sv_r[i];
      assign sif[i].lim_low   = low_r[i];
      assign sif[i].lim_high  = high_r[i];

      out_scaler u_scaler (
        .s (sif[i])
      );

      assign range_err[i] = sif[i].range_err;
      assign cfg_err[i]   = sif[i].cfg_err;
      assign hold_bad[i]  = hold_r[i] > `HOLD_MODE_MAXVAL;
      // unknown hold codes fall back to the clear level, the safest level
      assign mode = hold_bad[i] ? HM_CLEAR : hold_mode_e'(hold_r[i][1:0]);

      // any stop cause, including a setting error, hands the pin to hold [RULE11]
      assign stop[i] = !conv_enable[i] || range_err[i] || cfg_err[i] || bus_error;

      always_comb begin
        dac_nxt[i] = dac_r[i];
        if (!stop[i]) begin
          dac_nxt[i] = sif[i].code;
        end else begin
          case (mode) // [RULE15]
            HM_CLEAR: dac_nxt[i] = CLR_CODE;
            HM_LAST:  dac_nxt[i] = dac_r[i];
            HM_MAX:   dac_nxt[i] = MAX_CODE;
            default:  dac_nxt[i] = CLR_CODE;
          endcase
        end
      end

      // outputs move only with the host refresh cycle
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          dac_r[i] <= 16'h0000;
        end else if (io_refresh) begin
          dac_r[i] <= dac_nxt[i];
        end
      end

      // flag follows the live condition, so it clears itself [RULE9] [RULE17]
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          set_err_r[i] <= 1'b0;
        end else if (io_refresh) begin
          set_err_r[i] <= range_err[i];
        end
      end

      assign dac_out[i] = dac_r[i];
    end
  endgenerate

  // initial-setting errors stick until the unit is restarted (reset) [RULE16]
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_err_r <= 1'b0;
    end else if (|cfg_err) begin
      cfg_err_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hold_err_r <= 1'b0;
    end else if (|hold_bad) begin
      hold_err_r <= 1'b1;
    end
  end

  assign init_err = cfg_err_r || hold_err_r;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      status_word <= `STATUS_RST;
    end else begin
      status_word <= `STATUS_RST;
      status_word[`STAT_SET_ERR_LSB +: 4] <= set_err_r; // [RULE9]
      status_word[`STAT_CFG_ERR_BIT]      <= cfg_err_r; // [RULE16]
      status_word[`STAT_HOLD_ERR_BIT]     <= hold_err_r;
    end
  end

  // host fault is latched: the pin may recover before software looks
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      host_err_r <= 1'b0;
    end else if (bus_error) begin
      host_err_r <= 1'b1; // [RULE14]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      run_r      <= 1'b0;
      unit_err_r <= 1'b0;
    end else begin
      run_r      <= host_link_ok && !init_err; // [RULE12]
      unit_err_r <= (|set_err_r) || init_err; // [RULE13]
    end
  end

  assign run_lamp        = run_r;
  assign unit_error_lamp = unit_err_r;
  assign host_error_lamp = host_err_r;

  // checks
  property p_cfg_flag;
    @(posedge mclk) disable iff (!rst_b)
      (low_r[3] == high_r[3]) && (low_r[3] != 16'h0000) |-> ##2 status_word[8];
  endproperty
  a_cfg_flag: assert property (p_cfg_flag) else $error("cfg error not on bit 8"); // [RULE5]

  property p_range_flag;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && range_err[1] |-> ##2 status_word[1];
  endproperty
  a_range_flag: assert property (p_range_flag) else $error("set error flag missing"); // [RULE9]

  property p_flag_clear;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && !range_err[1] |-> ##2 !status_word[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("set error flag stuck"); // [RULE17]

  property p_hold_clear;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && stop[0] && (hold_r[0] == 16'h0000) |=> dac_out[0] == CLR_CODE;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("clear level not driven"); // [RULE15]

  property p_hold_last;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && stop[1] && (hold_r[1] == 16'h0001) |=> $stable(dac_out[1]);
  endproperty
  a_hold_last: assert property (p_hold_last) else $error("held level changed"); // [RULE11]

  property p_hold_max;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && stop[1] && (hold_r[1] == 16'h0002) |=> dac_out[1] == MAX_CODE;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("max level not driven"); // [RULE15]

  property p_convert;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && !stop[0] |=> dac_out[0] == $past(sif[0].code);
  endproperty
  a_convert: assert property (p_convert) else $error("converted code not driven"); // [RULE2]

  property p_bypass;
    @(posedge mclk) disable iff (!rst_b)
      (low_r[2] == 16'h0000) && (high_r[2] == 16'h0000) |-> !cfg_err[2] && sif[2].code == sv_r[2];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not transparent"); // [RULE6]

  property p_unit_lamp;
    @(posedge mclk) disable iff (!rst_b)
      (|set_err_r) |=> unit_error_lamp;
  endproperty
  a_unit_lamp: assert property (p_unit_lamp) else $error("unit lamp dark on alarm"); // [RULE13]

  property p_host_lamp;
    @(posedge mclk) disable iff (!rst_b)
      bus_error |=> host_error_lamp [*3];
  endproperty
  a_host_lamp: assert property (p_host_lamp) else $error("host lamp not latched"); // [RULE14]

  property p_run_lamp;
    @(posedge mclk) disable iff (!rst_b)
      !host_link_ok |=> !run_lamp;
  endproperty
  a_run_lamp: assert property (p_run_lamp) else $error("run lamp lit without link"); // [RULE12]

  property p_lim_range;
    @(posedge mclk) disable iff (!rst_b)
      ($signed(low_r[3]) > `SCALE_LIM_MAX) || ($signed(low_r[3]) < `SCALE_LIM_MIN)
        |-> cfg_err[3];
  endproperty
  a_lim_range: assert property (p_lim_range) else $error("bad limit accepted"); // [RULE1]

  property p_cfg_sticky;
    @(posedge mclk) disable iff (!rst_b)
      status_word[8] |=> status_word[8];
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky) else $error("cfg error bit dropped"); // [RULE16]

  property p_cfg_stop;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && cfg_err[3] && (hold_r[3] == 16'h0000) |=> dac_out[3] == CLR_CODE;
  endproperty
  a_cfg_stop: assert property (p_cfg_stop) else $error("bad limits still converted"); // [RULE5]

  property p_range_stop;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && range_err[1] && (hold_r[1] == 16'h0000) |=> dac_out[1] == CLR_CODE;
  endproperty
  a_range_stop: assert property (p_range_stop) else $error("over-range value driven"); // [RULE11]

  property p_low_zero;
    @(posedge mclk) disable iff (!rst_b)
      (sv_r[1] == low_r[1]) && !cfg_err[1] && !sif[1].bypass |-> sif[1].code == 16'h0000;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low limit not at zero"); // [RULE2]

  property p_high_full;
    @(posedge mclk) disable iff (!rst_b)
      (sv_r[2] == high_r[2]) && !cfg_err[2] && !sif[2].bypass |-> sif[2].code == FULL_CODE;
  endproperty
  a_high_full: assert property (p_high_full) else $error("high limit not full scale"); // [RULE3]

  property p_range_win;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && !stop[1] |=>
        ($signed(dac_out[1]) >= $signed(CLR_CODE)) &&
        ($signed(dac_out[1]) <= $signed(MAX_CODE));
  endproperty
  a_range_win: assert property (p_range_win) else $error("code outside window"); // [RULE4]

  property p_bad_hold_lamp;
    @(posedge mclk) disable iff (!rst_b)
      (hold_r[0] > `HOLD_MODE_MAXVAL) |-> ##2 unit_error_lamp;
  endproperty
  a_bad_hold_lamp: assert property (p_bad_hold_lamp) else $error("bad hold code dark"); // [RULE13]

  property p_run_init;
    @(posedge mclk) disable iff (!rst_b)
      init_err |=> !run_lamp;
  endproperty
  a_run_init: assert property (p_run_init) else $error("run lamp lit with bad setup"); // [RULE12]

  property p_run_on;
    @(posedge mclk) disable iff (!rst_b)
      host_link_ok && !init_err |=> run_lamp;
  endproperty
  a_run_on: assert property (p_run_on) else $error("run lamp dark in operation"); // [RULE12]

  property p_unit_dark;
    @(posedge mclk) disable iff (!rst_b)
      !(|set_err_r) && !init_err |=> !unit_error_lamp;
  endproperty
  a_unit_dark: assert property (p_unit_dark) else $error("unit lamp lit without alarm"); // [RULE13]

  property p_cfg_write;
    @(posedge mclk) disable iff (!rst_b)
      cfg_wr_en && (cfg_addr == `OUT4_SCALE_HIGH) |=> high_r[3] == $past(cfg_wr_data);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("limit word not stored"); // [RULE7]

  property p_conv_off;
    @(posedge mclk) disable iff (!rst_b)
      io_refresh && !conv_enable[0] && (hold_r[0] > `HOLD_MODE_MAXVAL)
        |=> dac_out[0] == CLR_CODE;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("bad hold code not clear"); // [RULE15]
endmodule

/* File: rtl/out_scaler.sv */
`include "aout_regs.svh"

module out_scaler (
  scale_if.calc s
);
  import aout_pkg::*;

  logic               lo_ok;
  logic               hi_ok;
  logic signed [33:0] span;
  logic signed [33:0] num;
  logic signed [33:0] prod;
  logic signed [33:0] quot;
  logic signed [33:0] val;

  // limits must lie inside +/-32000 [RULE1]
  assign lo_ok = (s.lim_low >= `SCALE_LIM_MIN) && (s.lim_low <= `SCALE_LIM_MAX);
  assign hi_ok = (s.lim_high >= `SCALE_LIM_MIN) && (s.lim_high <= `SCALE_LIM_MAX);

  // both limits zero: pass set value through, no error [RULE6]
  assign s.bypass = (s.lim_low == 16'sh0000) && (s.lim_high == 16'sh0000);

  // equal or out-of-range limits stop scaling [RULE5]
  assign s.cfg_err = !s.bypass && (!lo_ok || !hi_ok || (s.lim_low == s.lim_high));

  // 34 bits hold 65535 * 4000 with sign; signed divide truncates toward zero [RULE18]
  assign span = 34'(s.lim_high) - 34'(s.lim_low);
  assign num  = 34'(s.set_value) - 34'(s.lim_low);
  assign prod = num * `DAC_FULL_SCALE;
  // low limit maps to 0%, high to 100%; swapped limits give a falling slope [RULE2] [RULE3]
  assign quot = (span != 34'sh0_0000_0000) ? (prod / span) : 34'sh0_0000_0000;
  assign val  = s.bypass ? 34'(s.set_value) : quot;

  // only -5% .. +105% of full scale is converted [RULE4]
  assign s.range_err = !s.cfg_err && ((val < `DAC_CLR_LEVEL) || (val > `DAC_MAX_LEVEL));
  assign s.code      = val[15:0];
endmodule

/* File: rtl/scale_if.sv */
interface scale_if;
  import aout_pkg::*;
  word_t set_value;
  word_t lim_low;
  word_t lim_high;
  word_t code;
  logic  cfg_err;
  logic  range_err;
  logic  bypass;
  modport ctrl (output set_value, lim_low, lim_high, input code, cfg_err, range_err, bypass);
  modport calc (input set_value, lim_low, lim_high, output code, cfg_err, range_err, bypass);
endinterface

/* File: sim/host_cpu_model.sv */
module host_cpu_model #(
  parameter int UNIT = 3
) (
  input  wire logic        mclk,
  input  wire logic [15:0] status_word,
  output logic             cfg_wr_en,
  output logic [4:0]       cfg_addr,
  output logic [15:0]      cfg_wr_data,
  output logic             sv_wr_en,
  output logic [1:0]       sv_sel,
  output logic [15:0]      sv_wr_data,
  output logic             io_refresh
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CFG_BASE = 20000 + 100 * UNIT;
  localparam int STAT_BASE = 2000 + 10 * UNIT;
  initial begin
    {cfg_wr_en, cfg_addr, cfg_wr_data} = '0;
    {sv_wr_en, sv_sel, sv_wr_data, io_refresh} = '0;
  end
  // limits go out whole, one 16-bit word per write
  task automatic put_cfg(input int adr, input logic [15:0] d);
    @(negedge mclk);
    cfg_wr_en = 1'b1;
    cfg_addr = 5'(adr - CFG_BASE);
    cfg_wr_data = d;
    @(negedge mclk);
    cfg_wr_en = 1'b0;
  endtask
  task automatic put_sv(input logic [1:0] sel, input logic [15:0] d);
    @(negedge mclk);
    sv_wr_en = 1'b1;
    sv_sel = sel;
    sv_wr_data = d;
    @(negedge mclk);
    sv_wr_en = 1'b0;
  endtask
  // four idle cycles let outputs, flags and lamps all land
  task automatic refresh();
    @(negedge mclk);
    io_refresh = 1'b1;
    @(negedge mclk);
    io_refresh = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  // only the status word of this unit answers; other words read as unknown
  task automatic get_status(input int adr, output logic [15:0] d);
    d = (adr == STAT_BASE + 9) ? status_word : 16'hxxxx;
  endtask
endmodule

/* File: sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import aout_pkg::*;
  localparam int CB = 20000 + 100 * 3;
  localparam int SB = 2000 + 10 * 3 + 9;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  conv_enable = 4'hf;
  logic        host_link_ok = 1'b1;
  logic        bus_error = 1'b0;
  logic        cfg_wr_en, sv_wr_en, io_refresh;
  logic [4:0]  cfg_addr;
  logic [1:0]  sv_sel;
  logic [15:0] cfg_wr_data, sv_wr_data, status_word, st;
  out_bus_t    dac_out;
  logic        run_lamp, unit_error_lamp, host_error_lamp;
  int          mismatches = 0;
  int          n_compared = 0;
  always #25 mclk = ~mclk;
  aout_unit uut (.mclk(mclk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
    .cfg_wr_data(cfg_wr_data), .sv_wr_en(sv_wr_en), .sv_sel(sv_sel),
    .sv_wr_data(sv_wr_data), .io_refresh(io_refresh), .conv_enable(conv_enable),
    .host_link_ok(host_link_ok), .bus_error(bus_error), .status_word(status_word),
    .dac_out(dac_out), .run_lamp(run_lamp), .unit_error_lamp(unit_error_lamp),
    .host_error_lamp(host_error_lamp));
  host_cpu_model #(.UNIT(3)) host (.mclk(mclk), .status_word(status_word),
    .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data),
    .sv_wr_en(sv_wr_en), .sv_sel(sv_sel), .sv_wr_data(sv_wr_data),
    .io_refresh(io_refresh));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_bypass();
    host.put_sv(2'd0, 16'h03e8);
    host.refresh();
    host.get_status(SB, st);
    check("bypass dac", dac_out[0], 16'h03e8);
    check("bypass status", st, 16'h0000);
    check("run lamp", {15'h0000, run_lamp}, 16'h0001);
  endtask
  // out2 spans 0..10000 onto 0..4000, edges of the -5%..+105% window included
  task automatic t_linear();
    logic [15:0] sv [5] = '{16'h09c4, 16'hfe0c, 16'h2904, 16'hfe0d, 16'h0000};
    logic [15:0] ex [5] = '{16'h03e8, 16'hff38, 16'h1068, 16'hff39, 16'h0000};
    host.put_cfg(CB + 8, 16'h0000);
    host.put_cfg(CB + 9, 16'h2710);
    for (int i = 0; i < 5; i++) begin
      host.put_sv(2'd1, sv[i]);
      host.refresh();
      host.get_status(SB, st);
      check("linear dac", dac_out[1], ex[i]);
      check("linear status", st, 16'h0000);
    end
  endtask
  task automatic t_reverse();
    host.put_cfg(CB + 12, 16'h2710);
    host.put_cfg(CB + 13, 16'h0000);
    host.put_sv(2'd2, 16'h09c4);
    host.refresh();
    check("reverse dac", dac_out[2], 16'h0bb8);
    host.put_sv(2'd2, 16'h2904);
    host.refresh();
    check("reverse low end", dac_out[2], 16'hff38);
  endtask
  // hold codes 0, 1 and 2, each after a good value so that the held level is known
  task automatic t_range_err();
    logic [15:0] ex [3] = '{16'hff38, 16'h03e8, 16'h1068};
    for (int c = 0; c < 3; c++) begin
      host.put_cfg(CB + 7, 16'(c));
      host.put_sv(2'd1, 16'h09c4);
      host.refresh();
      host.put_sv(2'd1, 16'h2968);
      host.refresh();
      host.get_status(SB, st);
      check("range flag", st, 16'h0002);
      check("hold level", dac_out[1], ex[c]);
      check("unit lamp on", {15'h0000, unit_error_lamp}, 16'h0001);
      host.put_sv(2'd1, 16'h09c4);
      host.refresh();
      host.get_status(SB, st);
      check("flag cleared", st, 16'h0000);
      check("unit lamp off", {15'h0000, unit_error_lamp}, 16'h0000);
    end
  endtask
  task automatic t_host();
    @(negedge mclk);
    host_link_ok = 1'b0;
    repeat (3) @(negedge mclk);
    check("run lamp off", {15'h0000, run_lamp}, 16'h0000);
    host_link_ok = 1'b1;
    bus_error = 1'b1;
    host.refresh();
    check("bus error hold", dac_out[0], 16'hff38);
    bus_error = 1'b0;
    repeat (3) @(negedge mclk);
    check("host lamp", {15'h0000, host_error_lamp}, 16'h0001);
  endtask
  // a hold code past 2 is flagged, still converts, and acts as clear once stopped
  task automatic t_hold_code();
    host.put_cfg(CB + 3, 16'h0003);
    host.refresh();
    host.get_status(SB, st);
    check("bad hold status", st, 16'h0400);
    check("bad hold lamp", {15'h0000, unit_error_lamp}, 16'h0001);
    check("bad hold run", {15'h0000, run_lamp}, 16'h0000);
    check("bad hold live", dac_out[0], 16'h03e8);
    conv_enable = 4'he;
    host.refresh();
    check("enable off clear", dac_out[0], 16'hff38);
    conv_enable = 4'hf;
  endtask
  // equal limits, a limit past 32000, then the widest legal span
  task automatic t_cfg_err();
    logic [15:0] lo [3] = '{16'h0064, 16'h7d01, 16'h8300};
    logic [15:0] hi [3] = '{16'h0064, 16'h0000, 16'h7d00};
    logic [15:0] es [3] = '{16'h0100, 16'h0100, 16'h0000};
    logic [15:0] ed [3] = '{16'hff38, 16'hff38, 16'h07d0};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      host.put_cfg(CB + 16, lo[i]);
      host.put_cfg(CB + 17, hi[i]);
      host.put_sv(2'd3, 16'h0000);
      host.refresh();
      host.get_status(SB, st);
      check("cfg status", st, es[i]);
      check("cfg dac", dac_out[3], ed[i]);
      check("cfg lamp", {15'h0000, unit_error_lamp}, {15'h0000, es[i][8]});
    end
  endtask
  initial begin
    do_reset();
    t_bypass();
    t_linear();
    t_reverse();
    t_range_err();
    t_host();
    t_hold_code();
    t_cfg_err();
    tally_and_finish();
  end
endmodule
